// >>> rtl/phb_pkg.sv
// shared constants and carrier types for the loop b holdover and switching register slice
package phb_pkg;

  localparam int RW_COUNT = 20;

  // address, writable-bit mask and reset value of every stored byte register
  localparam logic [15:0] RW_ADDR [RW_COUNT] = '{
    16'h053d, 16'h053e, 16'h0540, 16'h0588, 16'h0589, 16'h058a, 16'h059b, 16'h059c,
    16'h059d, 16'h059e, 16'h059f, 16'h05a0, 16'h05a1, 16'h05a2,
    16'h05a4, 16'h05a5, 16'h05a6, 16'h05ac, 16'h05ad, 16'h05ae};
  localparam logic [7:0] RW_MASK [RW_COUNT] = '{
    8'h1f, 8'h1f, 8'hff, 8'h0f, 8'hff, 8'h1f, 8'hf2, 8'hc0,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h01, 8'h0f, 8'h09, 8'hff, 8'hff};
  localparam logic [7:0] RW_RESET [RW_COUNT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hb2, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam logic [15:0] ADDR_STATUS = 16'h053f;

  // indices into the stored register table
  localparam int IDX_COARSE_LEN = 0;
  localparam int IDX_COARSE_DLY = 1;
  localparam int IDX_RESERVED = 2;
  localparam int IDX_FINE_LEN = 3;
  localparam int IDX_DET_DLY_LO = 4;
  localparam int IDX_DET_DLY_HI = 5;
  localparam int IDX_EXIT_CTRL = 6;
  localparam int IDX_EXIT_CTRL2 = 7;
  localparam int IDX_EXIT_BW0 = 8;
  localparam int EXIT_BW_BYTES = 6;
  localparam int IDX_HSW_LIMIT = 14;
  localparam int IDX_HSW_ACTION = 15;
  localparam int IDX_RAMP = 16;
  localparam int IDX_OUT_CFG = 17;
  localparam int IDX_OUT_LMT_LO = 18;
  localparam int IDX_OUT_LMT_HI = 19;

  // field positions
  localparam int BIT_HIST_VALID = 1;
  localparam int BIT_QUICK = 2;
  localparam int BIT_REACQ_RAMP = 1;
  localparam int BIT_KEEP_HIST = 4;
  localparam int BIT_FREEZE_INT = 5;
  localparam int BIT_EXIT_BW_SEL = 6;
  localparam int BIT_EXIT_FIXED = 7;
  localparam int BIT_EXIT_ST_BO = 6;
  localparam int BIT_RAMP_NO_HIST = 7;
  localparam int BIT_RAMP_EN = 3;
  localparam int BIT_OUT_LMT_EN = 0;
  localparam int BIT_SETTLE_EN = 3;

  // ramp scale codes as left shifts, with the two fractional codes as right shifts
  localparam logic [2:0] SCALE_1 = 3'h0;
  localparam logic [2:0] SCALE_4 = 3'h1;
  localparam logic [2:0] SCALE_16 = 3'h2;
  localparam logic [2:0] SCALE_64 = 3'h3;
  localparam logic [2:0] SCALE_256 = 3'h4;
  localparam logic [2:0] SCALE_1024 = 3'h5;
  localparam logic [2:0] SCALE_QUARTER = 3'h6;
  localparam logic [2:0] SCALE_HALF = 3'h7;
  localparam int BASE_RATE_W = 16;
  localparam int RAMP_RATE_W = 26;

  // history samples needed before the history counts as valid
  localparam logic [15:0] HIST_SAMPLES_NEEDED = 16'h0100;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } phb_host_req_t;

  typedef struct packed {
    logic ref_lost_or_switched;
    logic ref_valid_presented;
    logic hist_sample;
    logic quick_acquire_active;
  } phb_core_stat_t;

  typedef struct packed {
    logic ramped_reacquire_select;
    logic keep_history_on_loss;
    logic freeze_integrator_only;
    logic exit_bw_select;
    logic exit_fixed_one_bit;
    logic exit_start_buildout;
    logic ramp_bypass_no_hist;
    logic ramped_switch_enable;
    logic exit_bw_apply;
    logic [4:0] coarse_measure_length;
    logic [4:0] coarse_measure_delay;
    logic [3:0] fine_measure_length;
    logic [12:0] detector_enable_delay;
    logic [7:0] hitless_limit;
    logic hitless_limit_response;
    logic output_limit_enable;
    logic settle_detect_enable;
    logic [15:0] output_limit_value;
    logic [7:0] reserved_update;
  } phb_cfg_t;

  typedef enum {PHB_NO_REF, PHB_ACCUM, PHB_FROZEN} phb_hist_state_t;

endpackage

// >>> rtl/phb_byte_reg.sv
// one stored byte register with a writable-bit mask
`timescale 1ns/100ps
module phb_byte_reg #(
  parameter logic [7:0] MASK = 8'hff,
  parameter logic [7:0] RESET = 8'h00
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] value
);
  typedef struct packed {
    logic [7:0] value;
  } phb_byte_state_t;

  phb_byte_state_t state;
  phb_byte_state_t next_state;

  // plain storage, no side effects on access
  always_comb begin
    next_state = state;
    if (wr_en) begin
      next_state.value = wdata & MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '{value: RESET};
    end else begin
      state <= next_state;
    end
  end

  assign value = state.value;
endmodule

// >>> rtl/phb_ramp_scale.sv
// final ramp rate: base rate times the selected scale multiplier
`timescale 1ns/100ps
module phb_ramp_scale (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [phb_pkg::BASE_RATE_W-1:0] base_ramp_rate,
  input wire logic [2:0] ramp_scale_code,
  output logic [phb_pkg::RAMP_RATE_W-1:0] ramp_rate
);
  typedef struct packed {
    logic [phb_pkg::RAMP_RATE_W-1:0] rate;
  } phb_ramp_state_t;

  phb_ramp_state_t state;
  phb_ramp_state_t next_state;
  logic [phb_pkg::RAMP_RATE_W-1:0] wide_base;

  assign wide_base = {{(phb_pkg::RAMP_RATE_W-phb_pkg::BASE_RATE_W){1'b0}}, base_ramp_rate};

  always_comb begin
    next_state = state;
    case (ramp_scale_code)
      phb_pkg::SCALE_1: next_state.rate = wide_base;
      phb_pkg::SCALE_4: next_state.rate = wide_base << 2;
      phb_pkg::SCALE_16: next_state.rate = wide_base << 4;
      phb_pkg::SCALE_64: next_state.rate = wide_base << 6;
      phb_pkg::SCALE_256: next_state.rate = wide_base << 8;
      phb_pkg::SCALE_1024: next_state.rate = wide_base << 10;
      phb_pkg::SCALE_QUARTER: next_state.rate = wide_base >> 2; // fraction truncates toward zero
      phb_pkg::SCALE_HALF: next_state.rate = wide_base >> 1;
      default: next_state.rate = wide_base;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '{rate: '0};
    end else begin
      state <= next_state;
    end
  end

  assign ramp_rate = state.rate;
endmodule

// >>> rtl/phb_ctrl.sv
// loop b holdover history, exit bandwidth and ramped switching register slice
`timescale 1ns/100ps
module phb_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire phb_pkg::phb_host_req_t host_req,
  output logic [7:0] host_rdata,
  input wire phb_pkg::phb_core_stat_t core_stat,
  input wire logic [phb_pkg::BASE_RATE_W-1:0] base_ramp_rate,
  input wire logic software_forced_holdover,
  input wire logic bandwidth_load_strobe,
  input wire logic full_soft_reset,
  input wire logic loop_b_soft_reset,
  output phb_pkg::phb_cfg_t cfg,
  output logic [8*phb_pkg::EXIT_BW_BYTES-1:0] exit_bandwidth_active,
  output logic [phb_pkg::RAMP_RATE_W-1:0] ramp_rate,
  output logic history_accumulate,
  output logic holdover_active,
  output logic freerun_active
);
  typedef struct packed {
    phb_pkg::phb_hist_state_t hist_state;
    logic [15:0] hist_count;
    logic history_valid_flag;
    logic quick_acquire_active;
    logic [8*phb_pkg::EXIT_BW_BYTES-1:0] exit_bw;
    logic [7:0] rdata;
  } phb_ctrl_state_t;

  phb_ctrl_state_t state;
  phb_ctrl_state_t next_state;

  logic [7:0] reg_value [phb_pkg::RW_COUNT];
  logic [phb_pkg::RW_COUNT-1:0] reg_hit;
  logic [8*phb_pkg::EXIT_BW_BYTES-1:0] exit_bw_staged;
  logic [7:0] read_mux;
  logic stop_event;

  // stored registers; writes to the status byte or unmapped addresses fall through
  genvar gi;
  generate
    for (gi = 0; gi < phb_pkg::RW_COUNT; gi++) begin : g_reg
      assign reg_hit[gi] = host_req.addr == phb_pkg::RW_ADDR[gi];
      phb_byte_reg #(
        .MASK(phb_pkg::RW_MASK[gi]),
        .RESET(phb_pkg::RW_RESET[gi])
      ) u_reg (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(host_req.wr && reg_hit[gi]),
        .wdata(host_req.wdata),
        .value(reg_value[gi])
      );
    end
    for (gi = 0; gi < phb_pkg::EXIT_BW_BYTES; gi++) begin : g_bw
      assign exit_bw_staged[8*gi +: 8] = reg_value[phb_pkg::IDX_EXIT_BW0 + gi];
    end
  endgenerate

  always_comb begin
    read_mux = 8'h00;
    for (int i = 0; i < phb_pkg::RW_COUNT; i++) begin
      if (reg_hit[i]) begin
        read_mux = reg_value[i];
      end
    end
    if (host_req.addr == phb_pkg::ADDR_STATUS) begin
      read_mux = 8'h00;
      read_mux[phb_pkg::BIT_HIST_VALID] = state.history_valid_flag;
      read_mux[phb_pkg::BIT_QUICK] = state.quick_acquire_active;
    end
  end

  // forced holdover also halts accumulation, just like a real input loss
  assign stop_event = core_stat.ref_lost_or_switched || software_forced_holdover;

  always_comb begin
    next_state = state;
    next_state.quick_acquire_active = core_stat.quick_acquire_active;
    if (host_req.rd) begin
      next_state.rdata = read_mux;
    end
    // only the full soft reset or the strobe move staged bytes into use
    if (bandwidth_load_strobe || full_soft_reset) begin
      next_state.exit_bw = exit_bw_staged;
    end
    case (state.hist_state)
      phb_pkg::PHB_ACCUM: begin
        if (stop_event) begin
          next_state.hist_state = phb_pkg::PHB_FROZEN;
          if (!reg_value[phb_pkg::IDX_EXIT_CTRL][phb_pkg::BIT_KEEP_HIST]) begin
            next_state.hist_count = 16'h0000;
            next_state.history_valid_flag = 1'b0;
          end
        end else if (core_stat.hist_sample && state.hist_count != phb_pkg::HIST_SAMPLES_NEEDED) begin
          next_state.hist_count = state.hist_count + 16'h0001;
          if (state.hist_count + 16'h0001 == phb_pkg::HIST_SAMPLES_NEEDED) begin
            next_state.history_valid_flag = 1'b1;
          end
        end
      end
      phb_pkg::PHB_NO_REF, phb_pkg::PHB_FROZEN: begin
        // a loss in the same cycle beats the returning reference
        if (core_stat.ref_valid_presented && !stop_event) begin
          next_state.hist_state = phb_pkg::PHB_ACCUM;
          next_state.hist_count = 16'h0000;
          next_state.history_valid_flag = 1'b0;
        end
      end
      default: next_state.hist_state = phb_pkg::PHB_NO_REF;
    endcase
    // loop-only soft reset restarts history but keeps bandwidth untouched
    if (loop_b_soft_reset) begin
      next_state.hist_state = phb_pkg::PHB_NO_REF;
      next_state.hist_count = 16'h0000;
      next_state.history_valid_flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '{hist_state: phb_pkg::PHB_NO_REF, hist_count: 16'h0000, history_valid_flag: 1'b0,
                 quick_acquire_active: 1'b0, exit_bw: '0, rdata: 8'h00};
    end else begin
      state <= next_state;
    end
  end

  phb_ramp_scale u_ramp (
    .clk(clk),
    .reset_n(reset_n),
    .base_ramp_rate(base_ramp_rate),
    .ramp_scale_code(reg_value[phb_pkg::IDX_RAMP][2:0]),
    .ramp_rate(ramp_rate)
  );

  assign host_rdata = state.rdata;
  assign exit_bandwidth_active = state.exit_bw;
  assign history_accumulate = state.hist_state == phb_pkg::PHB_ACCUM;
  // the flag at entry time picks the mode, also when software forces the holdover
  assign holdover_active = state.hist_state == phb_pkg::PHB_FROZEN && state.history_valid_flag;
  assign freerun_active = state.hist_state != phb_pkg::PHB_ACCUM && !state.history_valid_flag;

  always_comb begin
    cfg.ramped_reacquire_select = reg_value[phb_pkg::IDX_EXIT_CTRL][phb_pkg::BIT_REACQ_RAMP];
    cfg.keep_history_on_loss = reg_value[phb_pkg::IDX_EXIT_CTRL][phb_pkg::BIT_KEEP_HIST];
    cfg.freeze_integrator_only = reg_value[phb_pkg::IDX_EXIT_CTRL][phb_pkg::BIT_FREEZE_INT];
    cfg.exit_bw_select = reg_value[phb_pkg::IDX_EXIT_CTRL][phb_pkg::BIT_EXIT_BW_SEL];
    // stored as written; a zero here is a host fault, not checked in hardware
    cfg.exit_fixed_one_bit = reg_value[phb_pkg::IDX_EXIT_CTRL][phb_pkg::BIT_EXIT_FIXED];
    cfg.exit_start_buildout = reg_value[phb_pkg::IDX_EXIT_CTRL2][phb_pkg::BIT_EXIT_ST_BO];
    cfg.ramp_bypass_no_hist = reg_value[phb_pkg::IDX_EXIT_CTRL2][phb_pkg::BIT_RAMP_NO_HIST];
    cfg.ramped_switch_enable = reg_value[phb_pkg::IDX_RAMP][phb_pkg::BIT_RAMP_EN];
    cfg.exit_bw_apply = !reg_value[phb_pkg::IDX_RAMP][phb_pkg::BIT_RAMP_EN];
    cfg.coarse_measure_length = reg_value[phb_pkg::IDX_COARSE_LEN][4:0];
    cfg.coarse_measure_delay = reg_value[phb_pkg::IDX_COARSE_DLY][4:0];
    cfg.fine_measure_length = reg_value[phb_pkg::IDX_FINE_LEN][3:0];
    cfg.detector_enable_delay = {reg_value[phb_pkg::IDX_DET_DLY_HI][4:0], reg_value[phb_pkg::IDX_DET_DLY_LO]};
    cfg.hitless_limit = reg_value[phb_pkg::IDX_HSW_LIMIT];
    cfg.hitless_limit_response = reg_value[phb_pkg::IDX_HSW_ACTION][0];
    cfg.output_limit_enable = reg_value[phb_pkg::IDX_OUT_CFG][phb_pkg::BIT_OUT_LMT_EN];
    cfg.settle_detect_enable = reg_value[phb_pkg::IDX_OUT_CFG][phb_pkg::BIT_SETTLE_EN];
    cfg.output_limit_value = {reg_value[phb_pkg::IDX_OUT_LMT_HI], reg_value[phb_pkg::IDX_OUT_LMT_LO]};
    cfg.reserved_update = reg_value[phb_pkg::IDX_RESERVED];
  end

  a_status_hist_read: assert property (@(posedge clk) disable iff (!reset_n)
    host_req.rd && host_req.addr == phb_pkg::ADDR_STATUS |=>
      host_rdata[phb_pkg::BIT_HIST_VALID] == $past(state.history_valid_flag))
    else $error("history valid bit misread");

  a_status_quick_read: assert property (@(posedge clk) disable iff (!reset_n)
    core_stat.quick_acquire_active ##1 (host_req.rd && host_req.addr == phb_pkg::ADDR_STATUS) |=>
      host_rdata[phb_pkg::BIT_QUICK])
    else $error("quick acquire bit not reported");

  a_accum_stops: assert property (@(posedge clk) disable iff (!reset_n)
    history_accumulate && core_stat.ref_lost_or_switched && !loop_b_soft_reset |=>
      !history_accumulate && $stable(state.hist_count) or !$past(cfg.keep_history_on_loss))
    else $error("accumulation continued after loss");

  a_accum_restart: assert property (@(posedge clk) disable iff (!reset_n)
    !history_accumulate && core_stat.ref_valid_presented && !stop_event && !loop_b_soft_reset |=>
      history_accumulate && state.hist_count == 16'h0000 && !state.history_valid_flag)
    else $error("history not cleared on reference return");

  a_keep_history: assert property (@(posedge clk) disable iff (!reset_n)
    history_accumulate && stop_event && !loop_b_soft_reset |=>
      state.history_valid_flag == ($past(state.history_valid_flag) && $past(cfg.keep_history_on_loss)))
    else $error("history keep or clear wrong");

  a_exit_reset_value: assert property (@(posedge clk)
    !reset_n |=> reg_value[phb_pkg::IDX_EXIT_CTRL] == phb_pkg::RW_RESET[phb_pkg::IDX_EXIT_CTRL])
    else $error("exit control reset value wrong");

  a_bw_load_strobe: assert property (@(posedge clk) disable iff (!reset_n)
    bandwidth_load_strobe |=> exit_bandwidth_active == $past(exit_bw_staged))
    else $error("exit bandwidth not loaded by strobe");

  a_bw_loop_reset: assert property (@(posedge clk) disable iff (!reset_n)
    !bandwidth_load_strobe && !full_soft_reset |=> $stable(exit_bandwidth_active))
    else $error("exit bandwidth changed without load");

  a_ramp_max_scale: assert property (@(posedge clk) disable iff (!reset_n)
    reg_value[phb_pkg::IDX_RAMP][2:0] == phb_pkg::SCALE_1024 |=>
      ramp_rate == {$past(base_ramp_rate), 10'h000})
    else $error("1024x ramp rate wrong");

  a_ramp_quarter: assert property (@(posedge clk) disable iff (!reset_n)
    reg_value[phb_pkg::IDX_RAMP][2:0] == phb_pkg::SCALE_QUARTER |=>
      ramp_rate == {12'h000, $past(base_ramp_rate[15:2])})
    else $error("quarter ramp rate wrong");

  a_forced_mode: assert property (@(posedge clk) disable iff (!reset_n)
    software_forced_holdover ##1 software_forced_holdover |->
      (holdover_active == state.history_valid_flag) && (freerun_active == !state.history_valid_flag))
    else $error("forced mode choice wrong");
endmodule

// >>> tb/pll_b_holdover_switch_ctrl_tb.sv
// self-checking bench for the loop b holdover and switching register slice
`timescale 1ns/100ps
module pll_b_holdover_switch_ctrl_tb;
  logic clk;
  logic reset_n;
  phb_pkg::phb_host_req_t host_req;
  logic [7:0] host_rdata;
  phb_pkg::phb_core_stat_t core_stat;
  logic [15:0] base_ramp_rate;
  logic software_forced_holdover;
  logic bandwidth_load_strobe;
  logic full_soft_reset;
  logic loop_b_soft_reset;
  phb_pkg::phb_cfg_t cfg;
  logic [47:0] exit_bandwidth_active;
  logic [25:0] ramp_rate;
  logic history_accumulate;
  logic holdover_active;
  logic freerun_active;
  int failures;
  int samples_checked;
  int seed;
  // model: stored bytes, loaded bandwidth, history state 0 none, 1 accumulating, 2 frozen
  logic [7:0] mem [phb_pkg::RW_COUNT];
  logic [47:0] bw_model;
  logic [25:0] exp_rate;
  int hist_state;
  int hist_count;
  bit hist_flag;

  phb_ctrl DUT (.clk(clk), .reset_n(reset_n), .host_req(host_req), .host_rdata(host_rdata),
    .core_stat(core_stat), .base_ramp_rate(base_ramp_rate), .software_forced_holdover(software_forced_holdover),
    .bandwidth_load_strobe(bandwidth_load_strobe), .full_soft_reset(full_soft_reset),
    .loop_b_soft_reset(loop_b_soft_reset), .cfg(cfg), .exit_bandwidth_active(exit_bandwidth_active),
    .ramp_rate(ramp_rate), .history_accumulate(history_accumulate), .holdover_active(holdover_active),
    .freerun_active(freerun_active));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic cyc;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    host_req.wr = 1'b1;
    host_req.addr = a;
    host_req.wdata = d;
    cyc;
    host_req.wr = 1'b0;
    for (int i = 0; i < phb_pkg::RW_COUNT; i++)
      if (phb_pkg::RW_ADDR[i] == a) mem[i] = d & phb_pkg::RW_MASK[i];
    // idle edge so the next request never re-raises the strobe in the same step
    cyc;
  endtask

  task automatic reg_check(input logic [15:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a == phb_pkg::ADDR_STATUS) e = {5'h00, core_stat.quick_acquire_active, hist_flag, 1'b0};
    for (int i = 0; i < phb_pkg::RW_COUNT; i++)
      if (phb_pkg::RW_ADDR[i] == a) e = mem[i];
    host_req.rd = 1'b1;
    host_req.addr = a;
    cyc;
    host_req.rd = 1'b0;
    chk($sformatf("reg %h", a), {56'h0, host_rdata}, {56'h0, e});
    cyc;
  endtask

  // expected configuration word rebuilt from the stored bytes, in carrier field order
  task automatic cfg_check;
    phb_pkg::phb_cfg_t e;
    e = {mem[6][1], mem[6][4], mem[6][5], mem[6][6], mem[6][7], mem[7][6], mem[7][7], mem[16][3], ~mem[16][3],
      mem[0][4:0], mem[1][4:0], mem[3][3:0], mem[5][4:0], mem[4], mem[14], mem[15][0], mem[17][0], mem[17][3],
      mem[19], mem[18], mem[2]};
    chk("cfg low", cfg[63:0], e[63:0]);
    chk("cfg high", 64'(cfg[70:64]), 64'(e[70:64]));
  endtask

  task automatic check_all;
    for (int i = 0; i < phb_pkg::RW_COUNT; i++) reg_check(phb_pkg::RW_ADDR[i]);
    cfg_check;
    reg_check(phb_pkg::ADDR_STATUS);
    reg_check(16'h05a3);
  endtask

  task automatic state_check;
    chk("accumulate", history_accumulate, hist_state == 1);
    chk("holdover", holdover_active, hist_state == 2 && hist_flag);
    chk("freerun", freerun_active, hist_state != 1 && !hist_flag);
  endtask

  task automatic loop_reset;
    loop_b_soft_reset = 1'b1;
    cyc;
    loop_b_soft_reset = 1'b0;
    hist_state = 0;
    hist_count = 0;
    hist_flag = 0;
  endtask

  // drives the event inputs for n cycles, then one idle cycle, and steps the history model at each edge
  task automatic events(input bit lost, input bit valid, input bit samp, input int n);
    for (int k = 0; k <= n; k++) begin
      if (k == n) begin
        lost = 1'b0;
        valid = 1'b0;
        samp = 1'b0;
      end
      core_stat.ref_lost_or_switched = lost;
      core_stat.ref_valid_presented = valid;
      core_stat.hist_sample = samp;
      cyc;
      if (hist_state == 1 && (lost || software_forced_holdover)) begin
        hist_state = 2;
        if (!mem[phb_pkg::IDX_EXIT_CTRL][phb_pkg::BIT_KEEP_HIST]) begin
          hist_count = 0;
          hist_flag = 0;
        end
      end else if (valid && hist_state != 1 && !software_forced_holdover) begin
        hist_state = 1;
        hist_count = 0;
        hist_flag = 0;
      end else if (samp && hist_state == 1) begin
        if (hist_count < 65535) hist_count++;
        if (hist_count >= 256) hist_flag = 1;
      end
    end
  endtask

  task automatic bw_bytes;
    for (int i = 0; i < 6; i++) reg_write(16'h059d + 16'(i), 8'($random(seed)));
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    report_and_stop;
  end

  initial begin
    seed = 2;
    failures = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    host_req = '0;
    core_stat = '0;
    base_ramp_rate = 16'h0000;
    software_forced_holdover = 1'b0;
    bandwidth_load_strobe = 1'b0;
    full_soft_reset = 1'b0;
    loop_b_soft_reset = 1'b0;
    for (int i = 0; i < phb_pkg::RW_COUNT; i++) mem[i] = phb_pkg::RW_RESET[i];
    bw_model = '0;
    hist_state = 0;
    hist_count = 0;
    hist_flag = 0;
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    chk("ramp rate", ramp_rate, 64'h0);
    chk("exit bw", exit_bandwidth_active, bw_model);
    state_check;
    check_all;
    $display("test reset values done");

    // bit 7 of the exit control byte is always written as 1 by software
    for (int i = 0; i < phb_pkg::RW_COUNT; i++)
      reg_write(phb_pkg::RW_ADDR[i], (i == 6) ? (8'($random(seed)) | 8'h80) : 8'($random(seed)));
    reg_write(phb_pkg::ADDR_STATUS, 8'hff);
    reg_write(16'h05a3, 8'hff);
    check_all;
    chk("reacquire", cfg.ramped_reacquire_select, mem[6][1]);
    chk("keep", cfg.keep_history_on_loss, mem[6][4]);
    chk("freeze", cfg.freeze_integrator_only, mem[6][5]);
    $display("test register access done");

    for (int c = 0; c < 8; c++) begin
      base_ramp_rate = 16'($random(seed));
      reg_write(16'h05a6, {4'h0, c[0], c[2:0]});
      cyc;
      cyc;
      exp_rate = (c < 6) ? (26'(base_ramp_rate) << (2 * c)) : (26'(base_ramp_rate) >> (8 - c));
      chk("ramp rate", ramp_rate, exp_rate);
      chk("ramp enable", cfg.ramped_switch_enable, c[0]);
      chk("exit bw apply", cfg.exit_bw_apply, !c[0]);
    end
    $display("test ramp scale done");

    reg_write(16'h059b, 8'hb2);
    core_stat.quick_acquire_active = 1'b1;
    loop_reset;
    events(0, 1, 0, 1);
    state_check;
    events(0, 0, 1, 200);
    events(1, 0, 0, 1);
    events(0, 0, 1, 100);
    state_check;
    reg_check(phb_pkg::ADDR_STATUS);
    events(0, 1, 0, 1);
    events(0, 0, 1, 255);
    reg_check(phb_pkg::ADDR_STATUS);
    core_stat.quick_acquire_active = 1'b0;
    events(0, 0, 1, 1);
    reg_check(phb_pkg::ADDR_STATUS);
    events(1, 0, 0, 1);
    state_check;
    events(0, 1, 0, 1);
    state_check;
    reg_write(16'h059b, 8'ha2);
    events(0, 0, 1, 256);
    events(1, 0, 0, 1);
    state_check;
    reg_check(phb_pkg::ADDR_STATUS);
    reg_write(16'h059b, 8'hb2);
    events(0, 1, 0, 1);
    events(0, 0, 1, 256);
    software_forced_holdover = 1'b1;
    events(0, 0, 0, 1);
    state_check;
    events(0, 1, 0, 1);
    state_check;
    software_forced_holdover = 1'b0;
    loop_reset;
    events(0, 1, 0, 1);
    software_forced_holdover = 1'b1;
    events(0, 0, 0, 1);
    state_check;
    software_forced_holdover = 1'b0;
    $display("test history done");

    bw_bytes;
    loop_reset;
    chk("exit bw", exit_bandwidth_active, bw_model);
    bandwidth_load_strobe = 1'b1;
    cyc;
    bandwidth_load_strobe = 1'b0;
    cyc;
    bw_model = {mem[13], mem[12], mem[11], mem[10], mem[9], mem[8]};
    chk("exit bw", exit_bandwidth_active, bw_model);
    bw_bytes;
    chk("exit bw", exit_bandwidth_active, bw_model);
    full_soft_reset = 1'b1;
    cyc;
    full_soft_reset = 1'b0;
    cyc;
    bw_model = {mem[13], mem[12], mem[11], mem[10], mem[9], mem[8]};
    chk("exit bw", exit_bandwidth_active, bw_model);
    $display("test bandwidth load done");
    report_and_stop;
  end
endmodule
